//--- test/cfg_chk.sv
// Purpose: port assertions for the config bank
// Assumes: one clock, rstn async low
// Notes:   bound from tb_top
`default_nettype none
module cfg_chk import frontend_cfg_pkg::*; (
    input wire logic clk, rstn, wr_en, rd_en, conversions_active,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata, rdata,
    input wire input_route_t input_route_field,
    input wire logic inputs_to_positive_pin, reference_span_select, input_span_select,
    input wire logic synced_mode, auto_standby_select, power_down_bit, analog_powered
);
    timeunit 1ns / 1ps;
    // one domain, so one clocking and one disable
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_far; rd_en && addr > 4'h6 |=> rdata == 8'h00; endproperty
    a_far: assert property (p_far) else $error("unmapped read");
    property p_top; rd_en && addr == 4'h4 |=> rdata[7:2] == 6'h00; endproperty
    a_top: assert property (p_top) else $error("route top");
    property p_fe; rd_en && addr == 4'h5 |=> !rdata[7] && !rdata[2]; endproperty
    a_fe: assert property (p_fe) else $error("fe reserved");
    property p_om; rd_en && addr == 4'h6 |=> !rdata[6]; endproperty
    a_om: assert property (p_om) else $error("mode reserved");
    property p_cm; input_route_field == ROUTE_CM_TEST |-> inputs_to_positive_pin; endproperty
    a_cm: assert property (p_cm) else $error("cm test");
    property p_ovr; reference_span_select |-> !input_span_select; endproperty
    a_ovr: assert property (p_ovr) else $error("span");
    property p_syn; wr_en && addr == 4'h6 && wdata[4:3] == 2'h2 |=> synced_mode; endproperty
    a_syn: assert property (p_syn) else $error("sync");
    // two cycles held, so either reading of the flop passes
    sequence s_off_cause; power_down_bit || auto_standby_select && !conversions_active;
    endsequence
    property p_off; s_off_cause [*2] |=> !analog_powered; endproperty
    a_off: assert property (p_off) else $error("power");
endmodule : cfg_chk
`default_nettype wire

//--- test/host_bfm.sv
// Purpose: host side of the register port
// Assumes: called right after a rising edge
// Notes:   idle addr and wdata carry the inverse of the last value, strobes zero
`default_nettype none
module host_bfm (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en
);
    timeunit 1ns / 1ps;
    initial {addr, wdata, wr_en, rd_en} = 14'h0;
    // one strobe cycle, then a quiet edge so strobes never merge
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        {addr, wdata, wr_en, rd_en} <= {a, d, w, !w};
        @(posedge clk);
        {addr, wdata, wr_en, rd_en} <= {~a, ~d, 2'h0};
        @(posedge clk);
        // read data stand only in the cycle after the strobe; take them at its closing edge
        q = rdata;
    endtask : xfer
endmodule : host_bfm
`default_nettype wire

//--- test/tb_top.sv
// Purpose: random and corner tests of the config bank
// Assumes: host_bfm owns the register port
// Notes:   shadow bytes give every expectation
`default_nettype none
module tb_top;
    timeunit 1ns / 1ps;
    import frontend_cfg_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, conversions_active = 1'h0, wr_en, rd_en;
    logic [3:0] addr, a;
    logic [7:0] wdata, rdata, rv, d, m [4:7] = '{default: 8'h00};
    logic normal_polarity, inverted_polarity, input_pins_disconnect, inputs_to_midsupply;
    logic inputs_to_positive_pin, reference_span_select, input_span_select, synced_mode;
    logic midsupply_output_enable, pos_reference_precharge_en, pos_input_precharge_en;
    logic neg_input_precharge_en, extended_span_select, output_pin_function, one_shot_mode;
    logic start_stop_mode, low_speed_select, auto_standby_select, power_down_bit;
    logic analog_powered;
    input_route_t input_route_field;
    start_ctrl_t start_mode;
    int err_count = 0, check_count = 0;
    adc_frontend_config_regs DUT (.*);
    host_bfm u_host (.*);
    always #5 clk = ~clk;
    function automatic logic [7:0] wmask(input logic [3:0] i);
        return i == 4'h4 ? 8'h03 : i == 4'h5 ? 8'h7b : i == 4'h6 ? 8'hbf : 8'h00;
    endfunction : wmask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // first passes read reset values and write all ones everywhere except bit 4 of the mode register
    initial begin
        void'($urandom(32'h79c7));
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        for (int n = 0; n < 64; n++) begin
            a = 4'h4 + 4'(n < 4 ? n : $urandom % 4);
            // corners set reserved bits; random writes keep them zero and skip start code 3
            d = n < 4 ? (a == 4'h6 ? 8'hef : 8'hff) : 8'($urandom) & wmask(a);
            if (n >= 4 && a == 4'h6 && d[4:3] == 2'h3) d[4] = 1'h0;
            conversions_active <= 1'($urandom);
            u_host.xfer(1'h0, a, 8'h00, rv);
            chk(rv, m[a]);
            chk(analog_powered, !(m[6][0] || (m[6][1] && !conversions_active)));
            u_host.xfer(1'h1, a, d, rv);
            m[a] = d & wmask(a);
            chk({normal_polarity, inverted_polarity}, 2'h2 >> m[4]);
            chk({input_pins_disconnect, inputs_to_midsupply, inputs_to_positive_pin},
                {m[4][1:0] == 2'h2, m[4][1:0] == 2'h2, m[4][1:0] == 2'h3});
            chk(input_route_field, m[4][1:0]);
            chk({start_stop_mode, one_shot_mode, synced_mode},
                {m[6][4:3] == 2'h0, m[6][4:3] == 2'h1, m[6][4:3] == 2'h2});
            chk({auto_standby_select, power_down_bit}, m[6][1:0]);
            chk(input_span_select, m[5][6:5] == 2'h1);
            chk({reference_span_select, midsupply_output_enable}, {m[5][6], m[5][4]});
            chk({pos_input_precharge_en, neg_input_precharge_en}, m[5][1:0]);
            chk({pos_reference_precharge_en, extended_span_select}, {m[5][3], m[6][7]});
            chk({output_pin_function, start_mode, low_speed_select}, m[6][5:2]);
        end
        close_out();
    end
    // hang guard
    initial begin
        #600000 err_count++;
        close_out();
    end
endmodule : tb_top
bind adc_frontend_config_regs cfg_chk u_chk (.*);
`default_nettype wire

//--- verilog/adc_frontend_config_regs.sv
// Purpose: three configuration registers steering the converter front end
// Assumes: one clock, async active-low reset, one-cycle strobes
// Notes:   read data valid only in the cycle after the read strobe
//
// Summary of operation
// - input route register at 4h, upper bits zero
// - route code picks polarity or test shorts
// - front-end register at 5h, bits 7,2 zero
// - bit 6 picks low or high reference
// - high reference forces input span 1x
// - bit 5 picks 1x or 2x span
// - bit 4 enables mid-supply output pin
// - bit 3 enables reference precharge buffer
// - bit 1 enables positive input precharge
// - bit 0 enables negative input precharge
// - operating-mode register at 6h, bit 6 zero
// - start field selects start control mode
// - speed bit picks 25.6 or 3.2 MHz
// - standby bit enables auto power-down when stopped
// - power-down keeps only serial port, registers
`include "frontend_cfg_defines.svh"
`default_nettype none
module adc_frontend_config_regs #(
    parameter int unsigned REG_W = 8   // byte-wide bank; masks and decode assume eight bits
) (
    input  wire logic                         clk,
    input  wire logic                         rstn,
    input  wire logic [3:0]                   addr,
    input  wire logic [7:0]                   wdata,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    output logic      [7:0]                   rdata,
    input  wire logic                         conversions_active,
    output frontend_cfg_pkg::input_route_t    input_route_field,
    output logic                              normal_polarity,
    output logic                              inverted_polarity,
    output logic                              input_pins_disconnect,
    output logic                              inputs_to_midsupply,
    output logic                              inputs_to_positive_pin,
    output logic                              reference_span_select,
    output logic                              input_span_select,
    output logic                              midsupply_output_enable,
    output logic                              pos_reference_precharge_en,
    output logic                              pos_input_precharge_en,
    output logic                              neg_input_precharge_en,
    output logic                              extended_span_select,
    output logic                              output_pin_function,
    output frontend_cfg_pkg::start_ctrl_t     start_mode,
    output logic                              start_stop_mode,
    output logic                              one_shot_mode,
    output logic                              synced_mode,
    output logic                              low_speed_select,
    output logic                              auto_standby_select,
    output logic                              power_down_bit,
    output logic                              analog_powered
);
    import frontend_cfg_pkg::*;

    // masks and field positions are fixed for a byte, so refuse any other width
    if (REG_W != 8) begin : g_width_check
        $error("register width must be eight bits");
    end

    logic [7:0] route_q,  route_d;
    logic [7:0] fe_q,     fe_d;
    logic [7:0] mode_q,   mode_d;
    logic [7:0] rdata_q,  rdata_d;
    logic       analog_on_q, analog_on_d;

    // register writes; reserved positions masked off so they stay zero
    always_comb begin
        route_d = route_q;
        fe_d    = fe_q;
        mode_d  = mode_q;
        if (wr_en) begin
            unique case (addr)
                `ADDR_INPUT_ROUTE:    route_d = wdata & `WMASK_INPUT_ROUTE;
                `ADDR_FRONT_END:      fe_d    = wdata & `WMASK_FRONT_END;
                `ADDR_OPERATING_MODE: mode_d  = wdata & `WMASK_OPERATING_MODE;
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en) begin
            unique case (addr)
                `ADDR_INPUT_ROUTE:    rdata_d = route_q;
                `ADDR_FRONT_END:      rdata_d = fe_q;
                `ADDR_OPERATING_MODE: rdata_d = mode_q;
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    // analog power state: power-down wins, standby drops power only while stopped
    always_comb begin
        analog_on_d = 1'b1;
        if (mode_q[`OM_POWER_DOWN_BIT]) begin
            analog_on_d = 1'b0;
        end else if (mode_q[`OM_STANDBY_BIT] && !conversions_active) begin
            analog_on_d = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            route_q     <= `RST_INPUT_ROUTE;
            fe_q        <= `RST_FRONT_END;
            mode_q      <= `RST_OPERATING_MODE;
            rdata_q     <= 8'h00;
            analog_on_q <= 1'b1;
        end else begin
            route_q     <= route_d;
            fe_q        <= fe_d;
            mode_q      <= mode_d;
            rdata_q     <= rdata_d;
            analog_on_q <= analog_on_d;
        end
    end

    assign rdata = rdata_q;

    // input routing decode
    assign input_route_field      = input_route_t'(route_q[1:0]);
    assign normal_polarity        = (route_q[1:0] == ROUTE_NORMAL);
    assign inverted_polarity      = (route_q[1:0] == ROUTE_INVERTED);
    assign input_pins_disconnect  = (route_q[1:0] == ROUTE_MID_SHORT);
    assign inputs_to_midsupply    = (route_q[1:0] == ROUTE_MID_SHORT);
    assign inputs_to_positive_pin = (route_q[1:0] == ROUTE_CM_TEST);

    // front-end controls; the stored span bit reads back unchanged even when overridden
    assign reference_span_select      = fe_q[`FE_REF_SPAN_BIT];
    assign input_span_select          = fe_q[`FE_INP_SPAN_BIT]
                                        & ~fe_q[`FE_REF_SPAN_BIT];
    assign midsupply_output_enable    = fe_q[`FE_MIDSUPPLY_BIT];
    assign pos_reference_precharge_en = fe_q[`FE_REF_PRECHG_BIT];
    assign pos_input_precharge_en     = fe_q[`FE_POS_PRECHG_BIT];
    assign neg_input_precharge_en     = fe_q[`FE_NEG_PRECHG_BIT];

    // operating mode; reserved start code drives none of the mode strobes
    assign extended_span_select = mode_q[`OM_EXT_SPAN_BIT];
    assign output_pin_function  = mode_q[`OM_PIN_FUNC_BIT];
    assign start_mode           = start_ctrl_t'(mode_q[`OM_START_HI_BIT:`OM_START_LO_BIT]);
    assign start_stop_mode      = (start_mode == START_STOP_CTRL);
    assign one_shot_mode        = (start_mode == ONE_SHOT_CTRL);
    assign synced_mode          = (start_mode == SYNC_CTRL);
    assign low_speed_select     = mode_q[`OM_SPEED_BIT];
    assign auto_standby_select  = mode_q[`OM_STANDBY_BIT];
    assign power_down_bit       = mode_q[`OM_POWER_DOWN_BIT];
    assign analog_powered       = analog_on_q;
endmodule : adc_frontend_config_regs
`default_nettype wire

//--- verilog/frontend_cfg_defines.svh
// Purpose: offsets, field positions and reset values of the front-end config bank
// Assumes: byte-wide registers reached by index on a plain port
// Notes:   definitions only
`ifndef FRONTEND_CFG_DEFINES_SVH
`define FRONTEND_CFG_DEFINES_SVH

`define ADDR_INPUT_ROUTE      4'h4
`define ADDR_FRONT_END        4'h5
`define ADDR_OPERATING_MODE   4'h6

`define RST_INPUT_ROUTE       8'h00
`define RST_FRONT_END         8'h00
`define RST_OPERATING_MODE    8'h00

// writable bits per register; everything else is reserved and reads zero
`define WMASK_INPUT_ROUTE     8'h03
`define WMASK_FRONT_END       8'h7b
`define WMASK_OPERATING_MODE  8'hbf

`define FE_REF_SPAN_BIT       6
`define FE_INP_SPAN_BIT       5
`define FE_MIDSUPPLY_BIT      4
`define FE_REF_PRECHG_BIT     3
`define FE_POS_PRECHG_BIT     1
`define FE_NEG_PRECHG_BIT     0

`define OM_EXT_SPAN_BIT       7
`define OM_PIN_FUNC_BIT       5
`define OM_START_HI_BIT       4
`define OM_START_LO_BIT       3
`define OM_SPEED_BIT          2
`define OM_STANDBY_BIT        1
`define OM_POWER_DOWN_BIT     0

`endif

//--- verilog/frontend_cfg_pkg.sv
// Purpose: types shared by the front-end config bank
// Assumes: nothing beyond the defines header
// Notes:   codes follow the register encodings
`default_nettype none
package frontend_cfg_pkg;
    typedef enum logic [1:0] {
        ROUTE_NORMAL    = 2'h0,
        ROUTE_INVERTED  = 2'h1,
        ROUTE_MID_SHORT = 2'h2,
        ROUTE_CM_TEST   = 2'h3
    } input_route_t;

    typedef enum logic [1:0] {
        START_STOP_CTRL = 2'h0,
        ONE_SHOT_CTRL   = 2'h1,
        SYNC_CTRL       = 2'h2,
        START_RESERVED  = 2'h3
    } start_ctrl_t;
endpackage : frontend_cfg_pkg
`default_nettype wire
